//--- common/core_reg_map.vh
/*
  Register numbers, field positions and timing counts for the core register set.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef CORE_REG_MAP_VH
`define CORE_REG_MAP_VH

// special register numbers; bit 4 set marks a supervisor-only register
`define SPR_PRIV_BIT 4
`define SPR_INT_FLAGS 10'h001
`define SPR_LINK 10'h002
`define SPR_LOOP 10'h003
`define SPR_TOD_LOWER_RD 10'h00C
`define SPR_TOD_UPPER_RD 10'h00D
`define SPR_FAULT_CAUSE 10'h010
`define SPR_FAULT_ADDR 10'h011
`define SPR_DOWN_COUNT 10'h012
`define SPR_SAVE_ADDR 10'h013
`define SPR_SAVE_STATUS 10'h014
`define SPR_VERSION 10'h015
`define SPR_TOD_LOWER_WR 10'h016
`define SPR_TOD_UPPER_WR 10'h017
`define SPR_DATA_MISS 10'h018
`define SPR_INSTR_MISS 10'h019
`define SPR_PRIMARY_GROUP 10'h01A
`define SPR_SECONDARY_GROUP 10'h01B
`define SPR_INSTR_CMP 10'h01C
`define SPR_DATA_CMP 10'h01D
`define SPR_REAL_PAGE 10'h01E
`define SPR_CONFIG_TWO 10'h01F
`define SPR_INSTR_BP 10'h030
`define SPR_INSTR_BP2 10'h031
`define SPR_DATA_BP 10'h032
`define SPR_DATA_BP2 10'h033
`define SPR_INSTR_BP_CTRL 10'h034
`define SPR_DATA_BP_CTRL 10'h035
`define SPR_CRIT_ADDR 10'h036
`define SPR_CRIT_STATUS 10'h037
`define SPR_SCRATCH_BASE 10'h050
`define SPR_IXLT_BASE 10'h070
`define SPR_DXLT_BASE 10'h090
`define SPR_GROUP_MASK 10'h3F0
`define SPR_SCRATCH_MASK 10'h3F8

// machine state fields
`define MS_UM_BIT 14
`define MS_EE_BIT 15
`define MS_CE_BIT 17
`define MS_RESET 32'h0000_0000

// integer exception flag fields
`define IEF_SO_BIT 31
`define IEF_OV_BIT 30
`define IEF_CA_BIT 29
`define IEF_COUNT_HI 6

// data fault cause breakpoint bit
`define FAULT_BP_BIT 9

// implementation config two fields
`define CFG_LE_BIT 3
`define CFG_WAYLOCK_HI 2
`define CFG_HIBAT_BIT 18

// breakpoint enable bits
`define IBP_EN_BIT 1
`define DBP_WR_BIT 1
`define DBP_RD_BIT 0

// divider count at which a bus clock tick steps the timers; one step per four ticks
`define TIMER_DIV 2'h3

`endif

//--- hdl/core_register_set.v
/*
  Architected register set of a 32-bit core: integer and float arrays, condition
  flags, machine state, segment copies, special registers and timers.
  Assumes the execute side issues requests synchronous to clk and that bus_tick
  pulses once per bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_reg_map.vh"
module core_register_set #(
  parameter [31:0] VERSION_ID = 32'h0000_0101, // arbitrary value
  parameter EXTENDED = 1
)(
  input wire clk,
  input wire rst,
  input wire [4:0] int_rd_a_idx,
  input wire [4:0] int_rd_b_idx,
  output reg [31:0] int_rd_a_data,
  output reg [31:0] int_rd_b_data,
  input wire int_we,
  input wire [4:0] int_wr_idx,
  input wire [31:0] int_wr_data,
  input wire [4:0] float_rd_idx,
  output reg [63:0] float_rd_data,
  input wire float_we,
  input wire [4:0] float_wr_idx,
  input wire [63:0] float_wr_data,
  input wire [7:0] flags_field_we,
  input wire [31:0] flags_field_data,
  output reg [31:0] condition_flags,
  input wire seg_we,
  input wire [3:0] seg_wr_idx,
  input wire [31:0] seg_wr_data,
  input wire [3:0] seg_data_idx,
  output reg [31:0] seg_data_out,
  input wire [3:0] seg_fetch_idx,
  output reg [31:0] seg_fetch_out,
  input wire ms_we,
  input wire [31:0] ms_wr_data,
  output reg [31:0] machine_state,
  input wire spr_req,
  input wire spr_write,
  input wire [9:0] spr_num,
  input wire [31:0] spr_wdata,
  output reg [31:0] spr_rdata,
  output reg spr_ack,
  output reg spr_unmapped,
  output reg priv_fault,
  input wire loop_dec,
  output wire loop_zero,
  output reg [31:0] loop_counter,
  input wire link_we,
  input wire [31:0] link_addr,
  output reg [31:0] branch_link_address,
  input wire flags_update,
  input wire flags_ov,
  input wire flags_ca,
  output reg [31:0] integer_exception_flags,
  input wire exc_take,
  input wire [31:0] exc_pc,
  input wire exc_return,
  input wire crit_int,
  input wire crit_return,
  output reg crit_taken,
  output reg restore_valid,
  output reg [31:0] restore_pc,
  input wire data_fault,
  input wire align_fault,
  input wire fault_is_bp,
  input wire [31:0] fault_cause,
  input wire [31:0] fault_ea,
  input wire bus_tick,
  input wire tb_enable,
  output reg dec_exception,
  input wire instr_miss,
  input wire data_miss,
  input wire [31:0] miss_ea,
  input wire [31:0] miss_primary,
  input wire [31:0] miss_secondary,
  input wire [31:0] miss_compare,
  input wire dispatch_valid,
  input wire [31:0] dispatch_addr,
  output wire instr_bp_hit,
  input wire data_access,
  input wire data_is_write,
  input wire [31:0] data_addr,
  output wire data_bp_hit,
  output wire little_endian_en,
  output wire [2:0] way_lock,
  output wire high_bat_en
);
  localparam EXT = (EXTENDED != 0) ? 1'b1 : 1'b0;

  reg [31:0] int_regs [0:31];
  reg [63:0] float_regs [0:31];
  reg [31:0] seg_main [0:15];
  reg [31:0] seg_shadow [0:15];
  reg [31:0] ixlt [0:15];
  reg [31:0] dxlt [0:15];
  reg [31:0] scratch [0:7];
  reg [31:0] fault_cause_reg, fault_addr_reg, down_counter, save_addr, save_status;
  reg [63:0] time_of_day;
  reg [31:0] dmisa_reg, imisa_reg, prim_reg, sec_reg, icwd_reg, dcwd_reg, real_page_reg;
  reg [31:0] config_two, ibp_reg, ibp2_reg, dbp_reg, dbp2_reg, ibp_ctrl, dbp_ctrl;
  reg [31:0] crit_addr, crit_status;
  reg [1:0] tick_div;
  reg [31:0] sel_val;
  reg sel_hit;
  integer i;

  wire user_mode = machine_state[`MS_UM_BIT];
  wire quarter_tick = bus_tick & (tick_div == `TIMER_DIV);
  wire [3:0] grp_idx = spr_num[3:0];
  wire bat_ok = ~grp_idx[3] | (EXT & config_two[`CFG_HIBAT_BIT]);
  wire is_ixlt = (spr_num & `SPR_GROUP_MASK) == `SPR_IXLT_BASE;
  wire is_dxlt = (spr_num & `SPR_GROUP_MASK) == `SPR_DXLT_BASE;
  wire is_scr = (spr_num & `SPR_SCRATCH_MASK) == `SPR_SCRATCH_BASE;
  wire scr_ok = ~grp_idx[2] | EXT;

  // supervisor-only when number bit 4 set and caller in user mode
  function spr_refused;
    input [9:0] num;
    input umode;
    begin
      spr_refused = num[`SPR_PRIV_BIT] & umode;
    end
  endfunction

  wire spr_ok = sel_hit & ~spr_refused(spr_num, user_mode);
  wire spr_wr = spr_req & spr_write & spr_ok;
  wire ms_wr = ms_we & ~user_mode;
  wire seg_wr = seg_we & ~user_mode;
  wire rfi_ok = exc_return & ~user_mode;
  wire rfci_ok = crit_return & ~user_mode & EXT;
  wire crit_ok = EXT & crit_int & machine_state[`MS_CE_BIT] & ~exc_take;

  assign loop_zero = (loop_counter == 32'h0000_0000);
  assign instr_bp_hit = dispatch_valid &
    ((ibp_reg[`IBP_EN_BIT] & (ibp_reg[31:2] == dispatch_addr[31:2])) |
     (EXT & ibp2_reg[`IBP_EN_BIT] & (ibp2_reg[31:2] == dispatch_addr[31:2])));
  assign data_bp_hit = data_access &
    (((data_is_write ? dbp_reg[`DBP_WR_BIT] : dbp_reg[`DBP_RD_BIT]) & (dbp_reg[31:3] == data_addr[31:3])) |
     (EXT & (data_is_write ? dbp2_reg[`DBP_WR_BIT] : dbp2_reg[`DBP_RD_BIT]) &
      (dbp2_reg[31:3] == data_addr[31:3])));
  assign little_endian_en = EXT & config_two[`CFG_LE_BIT];
  assign way_lock = config_two[`CFG_WAYLOCK_HI:0];
  assign high_bat_en = EXT & config_two[`CFG_HIBAT_BIT];

  // read selection for move-from; every value is one 32-bit word
  always @*
  begin
    sel_val = 32'h0000_0000;
    sel_hit = 1'b1;
    case (spr_num)
      `SPR_INT_FLAGS: sel_val = integer_exception_flags;
      `SPR_LINK: sel_val = branch_link_address;
      `SPR_LOOP: sel_val = loop_counter;
      `SPR_TOD_LOWER_RD: sel_val = time_of_day[31:0];
      `SPR_TOD_UPPER_RD: sel_val = time_of_day[63:32];
      `SPR_FAULT_CAUSE: sel_val = fault_cause_reg;
      `SPR_FAULT_ADDR: sel_val = fault_addr_reg;
      `SPR_DOWN_COUNT: sel_val = down_counter;
      `SPR_SAVE_ADDR: sel_val = save_addr;
      `SPR_SAVE_STATUS: sel_val = save_status;
      `SPR_VERSION: sel_val = VERSION_ID;
      `SPR_TOD_LOWER_WR: sel_val = time_of_day[31:0];
      `SPR_TOD_UPPER_WR: sel_val = time_of_day[63:32];
      `SPR_DATA_MISS: sel_val = dmisa_reg;
      `SPR_INSTR_MISS: sel_val = imisa_reg;
      `SPR_PRIMARY_GROUP: sel_val = prim_reg;
      `SPR_SECONDARY_GROUP: sel_val = sec_reg;
      `SPR_INSTR_CMP: sel_val = icwd_reg;
      `SPR_DATA_CMP: sel_val = dcwd_reg;
      `SPR_REAL_PAGE: sel_val = real_page_reg;
      `SPR_CONFIG_TWO: sel_val = config_two;
      `SPR_INSTR_BP: sel_val = ibp_reg;
      `SPR_INSTR_BP2: begin sel_val = ibp2_reg; sel_hit = EXT; end
      `SPR_DATA_BP: begin sel_val = dbp_reg; sel_hit = EXT; end
      `SPR_DATA_BP2: begin sel_val = dbp2_reg; sel_hit = EXT; end
      `SPR_INSTR_BP_CTRL: begin sel_val = ibp_ctrl; sel_hit = EXT; end
      `SPR_DATA_BP_CTRL: begin sel_val = dbp_ctrl; sel_hit = EXT; end
      `SPR_CRIT_ADDR: begin sel_val = crit_addr; sel_hit = EXT; end
      `SPR_CRIT_STATUS: begin sel_val = crit_status; sel_hit = EXT; end
      default:
      begin
        if (is_ixlt)
        begin
          sel_val = ixlt[grp_idx];
          sel_hit = bat_ok;
        end
        else if (is_dxlt)
        begin
          sel_val = dxlt[grp_idx];
          sel_hit = bat_ok;
        end
        else if (is_scr)
        begin
          sel_val = scratch[grp_idx[2:0]];
          sel_hit = scr_ok;
        end
        else
          sel_hit = 1'b0;
      end
    endcase
  end

  // register arrays: no reset, written by the execute side
  always @(posedge clk)
  begin
    if (int_we)
      int_regs[int_wr_idx] <= int_wr_data;
    if (float_we)
      float_regs[float_wr_idx] <= float_wr_data;
    if (seg_wr)
    begin
      seg_main[seg_wr_idx] <= seg_wr_data;
      seg_shadow[seg_wr_idx] <= seg_wr_data;
    end
    int_rd_a_data <= int_regs[int_rd_a_idx];
    int_rd_b_data <= int_regs[int_rd_b_idx];
    float_rd_data <= float_regs[float_rd_idx];
    seg_data_out <= seg_main[seg_data_idx];
    seg_fetch_out <= seg_shadow[seg_fetch_idx];
    if (spr_wr & is_ixlt)
      ixlt[grp_idx] <= spr_wdata;
    if (spr_wr & is_dxlt)
      dxlt[grp_idx] <= spr_wdata;
    if (spr_wr & is_scr)
      scratch[grp_idx[2:0]] <= spr_wdata;
  end

  // control and special registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      condition_flags <= 32'h0000_0000;
      machine_state <= `MS_RESET;
      loop_counter <= 32'h0000_0000;
      branch_link_address <= 32'h0000_0000;
      integer_exception_flags <= 32'h0000_0000;
      fault_cause_reg <= 32'h0000_0000;
      fault_addr_reg <= 32'h0000_0000;
      down_counter <= 32'hFFFF_FFFF;
      save_addr <= 32'h0000_0000;
      save_status <= 32'h0000_0000;
      time_of_day <= 64'h0000_0000_0000_0000;
      dmisa_reg <= 32'h0000_0000;
      imisa_reg <= 32'h0000_0000;
      prim_reg <= 32'h0000_0000;
      sec_reg <= 32'h0000_0000;
      icwd_reg <= 32'h0000_0000;
      dcwd_reg <= 32'h0000_0000;
      real_page_reg <= 32'h0000_0000;
      config_two <= 32'h0000_0000;
      ibp_reg <= 32'h0000_0000;
      ibp2_reg <= 32'h0000_0000;
      dbp_reg <= 32'h0000_0000;
      dbp2_reg <= 32'h0000_0000;
      ibp_ctrl <= 32'h0000_0000;
      dbp_ctrl <= 32'h0000_0000;
      crit_addr <= 32'h0000_0000;
      crit_status <= 32'h0000_0000;
      tick_div <= 2'h0;
      spr_rdata <= 32'h0000_0000;
      spr_ack <= 1'b0;
      spr_unmapped <= 1'b0;
      priv_fault <= 1'b0;
      crit_taken <= 1'b0;
      restore_valid <= 1'b0;
      restore_pc <= 32'h0000_0000;
      dec_exception <= 1'b0;
    end
    else
    begin
      // move answers one cycle after the request
      spr_ack <= spr_req & spr_ok;
      spr_unmapped <= spr_req & ~sel_hit;
      spr_rdata <= (spr_req & ~spr_write & spr_ok) ? sel_val : 32'h0000_0000;
      priv_fault <= (spr_req & sel_hit & ~spr_ok) |
        (user_mode & (ms_we | seg_we | exc_return | crit_return));
      for (i = 0; i < 8; i = i + 1)
        if (flags_field_we[i])
          condition_flags[4*i +: 4] <= flags_field_data[4*i +: 4];
      if (spr_wr)
      begin
        case (spr_num)
          `SPR_INT_FLAGS: integer_exception_flags <= spr_wdata;
          `SPR_LINK: branch_link_address <= spr_wdata;
          `SPR_LOOP: loop_counter <= spr_wdata;
          `SPR_FAULT_CAUSE: fault_cause_reg <= spr_wdata;
          `SPR_FAULT_ADDR: fault_addr_reg <= spr_wdata;
          `SPR_SAVE_ADDR: save_addr <= spr_wdata;
          `SPR_SAVE_STATUS: save_status <= spr_wdata;
          `SPR_PRIMARY_GROUP: prim_reg <= spr_wdata;
          `SPR_SECONDARY_GROUP: sec_reg <= spr_wdata;
          `SPR_INSTR_CMP: icwd_reg <= spr_wdata;
          `SPR_DATA_CMP: dcwd_reg <= spr_wdata;
          `SPR_REAL_PAGE: real_page_reg <= spr_wdata;
          `SPR_CONFIG_TWO: config_two <= spr_wdata;
          `SPR_INSTR_BP: ibp_reg <= spr_wdata;
          `SPR_INSTR_BP2: ibp2_reg <= spr_wdata;
          `SPR_DATA_BP: dbp_reg <= spr_wdata;
          `SPR_DATA_BP2: dbp2_reg <= spr_wdata;
          `SPR_INSTR_BP_CTRL: ibp_ctrl <= spr_wdata;
          `SPR_DATA_BP_CTRL: dbp_ctrl <= spr_wdata;
          `SPR_CRIT_ADDR: crit_addr <= spr_wdata;
          `SPR_CRIT_STATUS: crit_status <= spr_wdata;
          default: ; // version and miss registers ignore writes
        endcase
      end
      if (loop_dec)
        loop_counter <= loop_counter - 32'h0000_0001;
      if (link_we)
        branch_link_address <= link_addr;
      // summary overflow is sticky: a hardware set beats a software clear
      if (flags_update)
      begin
        integer_exception_flags[`IEF_OV_BIT] <= flags_ov;
        integer_exception_flags[`IEF_CA_BIT] <= flags_ca;
        if (flags_ov)
          integer_exception_flags[`IEF_SO_BIT] <= 1'b1;
      end
      if (data_fault)
        fault_cause_reg <= fault_is_bp ? (fault_cause | (32'h0000_0001 << `FAULT_BP_BIT)) : fault_cause;
      if (data_fault | align_fault)
        fault_addr_reg <= fault_ea;
      if (data_miss)
      begin
        dmisa_reg <= miss_ea;
        dcwd_reg <= miss_compare;
      end
      if (instr_miss)
      begin
        imisa_reg <= miss_ea;
        icwd_reg <= miss_compare;
      end
      if (data_miss | instr_miss)
      begin
        prim_reg <= miss_primary;
        sec_reg <= miss_secondary;
      end
      // timers; a software write in the same cycle wins over the step
      if (bus_tick)
        tick_div <= tick_div + 2'h1;
      dec_exception <= 1'b0;
      if (spr_wr & (spr_num == `SPR_DOWN_COUNT))
        down_counter <= spr_wdata;
      else if (quarter_tick)
      begin
        down_counter <= down_counter - 32'h0000_0001;
        dec_exception <= (down_counter == 32'h0000_0000);
      end
      if (spr_wr & (spr_num == `SPR_TOD_LOWER_WR))
        time_of_day[31:0] <= spr_wdata;
      else if (spr_wr & (spr_num == `SPR_TOD_UPPER_WR))
        time_of_day[63:32] <= spr_wdata;
      else if (quarter_tick & tb_enable)
        time_of_day <= time_of_day + 64'h0000_0000_0000_0001;
      // exception entry and return
      crit_taken <= crit_ok;
      restore_valid <= rfi_ok | rfci_ok;
      if (ms_wr)
        machine_state <= ms_wr_data;
      if (exc_take)
      begin
        save_addr <= exc_pc;
        save_status <= machine_state;
        machine_state <= machine_state & ~((32'h0000_0001 << `MS_UM_BIT) | (32'h0000_0001 << `MS_EE_BIT));
      end
      else if (crit_ok)
      begin
        crit_addr <= exc_pc;
        crit_status <= machine_state;
        machine_state <= machine_state & ~((32'h0000_0001 << `MS_UM_BIT) |
          (32'h0000_0001 << `MS_EE_BIT) | (32'h0000_0001 << `MS_CE_BIT));
      end
      else if (rfi_ok)
      begin
        machine_state <= save_status;
        restore_pc <= save_addr;
      end
      else if (rfci_ok)
      begin
        machine_state <= crit_status;
        restore_pc <= crit_addr;
      end
    end
  end
endmodule // core_register_set
`default_nettype wire

//--- verif/core_register_set_assertions.sv
/*
  Concurrent checks on the ports of core_register_set.
  Assumes it is bound to the design from tb_top; one clock domain, reset rst.
*/
`timescale 1ns/1ps
`default_nettype none
module core_register_set_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic spr_req,
  input wire logic [9:0] spr_num,
  input wire logic spr_ack,
  input wire logic spr_unmapped,
  input wire logic priv_fault,
  input wire logic [31:0] machine_state,
  input wire logic ms_we,
  input wire logic exc_take,
  input wire logic exc_return,
  input wire logic crit_int,
  input wire logic crit_taken,
  input wire logic restore_valid,
  input wire logic loop_dec,
  input wire logic [31:0] loop_counter,
  input wire logic link_we,
  input wire logic [31:0] link_addr,
  input wire logic [31:0] branch_link_address,
  input wire logic flags_update,
  input wire logic flags_ov,
  input wire logic [31:0] integer_exception_flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  spr_answer_a: assert property (spr_req |=> $onehot({spr_ack, spr_unmapped, priv_fault}))
    else $error("special move not answered once");
  no_answer_a: assert property (!spr_req |=> !spr_ack && !spr_unmapped)
    else $error("answer without request");
  user_spr_a: assert property (spr_req && machine_state[14] && spr_num[4] |=> priv_fault && !spr_ack)
    else $error("supervisor register reached from user mode");
  user_ms_a: assert property (ms_we && machine_state[14] && !exc_take && !crit_int
    |=> priv_fault && $stable(machine_state))
    else $error("machine state changed from user mode");
  exc_clear_a: assert property (exc_take && !ms_we |=> !machine_state[14] && !machine_state[15])
    else $error("exception did not enter supervisor");
  crit_gate_a: assert property (crit_taken |-> $past(crit_int) && $past(machine_state[17]) && !$past(exc_take))
    else $error("critical exception taken without cause");
  ret_restore_a: assert property (exc_return && !machine_state[14] && !exc_take |=> restore_valid)
    else $error("return did not restore");
  loop_step_a: assert property (loop_dec && !spr_req |=> loop_counter == $past(loop_counter) - 32'h1)
    else $error("loop counter did not step down");
  link_load_a: assert property (link_we |=> branch_link_address == $past(link_addr))
    else $error("link address not loaded");
  sticky_ov_a: assert property (flags_update && flags_ov |=> integer_exception_flags[31:30] == 2'h3)
    else $error("overflow flags not set");
endmodule // core_register_set_checker
`default_nettype wire

//--- verif/tb_top.sv
/*
  Self-checking bench for core_register_set, driven at the falling edge.
  Assumes core_reg_map.vh on the include path and the checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_reg_map.vh"
module tb_top;
  localparam logic [31:0] VER = 32'h0000_0A5C; // arbitrary value
  logic clk, rst, int_we, float_we, seg_we, ms_we, spr_req, spr_write, loop_dec, link_we, flags_update;
  logic flags_ov, flags_ca, exc_take, exc_return, crit_int, crit_return, data_fault, align_fault, fault_is_bp;
  logic bus_tick, tb_enable, instr_miss, data_miss, dispatch_valid, data_access, data_is_write;
  logic spr_ack, spr_unmapped, priv_fault, loop_zero, crit_taken, restore_valid, dec_exception, instr_bp_hit;
  logic data_bp_hit, little_endian_en, high_bat_en;
  logic [2:0] way_lock, st;
  logic [3:0] seg_wr_idx, seg_data_idx, seg_fetch_idx;
  logic [4:0] int_rd_a_idx, int_rd_b_idx, int_wr_idx, float_rd_idx, float_wr_idx;
  logic [7:0] flags_field_we;
  logic [9:0] spr_num;
  logic [31:0] int_rd_a_data, int_rd_b_data, int_wr_data, flags_field_data, condition_flags, seg_wr_data, r;
  logic [31:0] seg_data_out, seg_fetch_out, ms_wr_data, machine_state, spr_wdata, spr_rdata, loop_counter;
  logic [31:0] link_addr, branch_link_address, integer_exception_flags, exc_pc, restore_pc, fault_cause;
  logic [31:0] fault_ea, miss_ea, miss_primary, miss_secondary, miss_compare, dispatch_addr, data_addr;
  logic [63:0] float_rd_data, float_wr_data;
  int error_cnt = 0;
  int n_checks = 0;
  int hits;
  core_register_set #(.VERSION_ID(VER)) dut (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one special move: request for one cycle, answer sampled in the next
  task automatic special_purpose_register(input logic w, input logic [9:0] n, input logic [31:0] d);
    cyc(1);
    {spr_req, spr_write, spr_num, spr_wdata} = {1'b1, w, n, d};
    cyc(1);
    spr_req = 1'b0;
    r = spr_rdata;
    st = {priv_fault, spr_unmapped, spr_ack};
  endtask
  task automatic rd(input logic [9:0] n, input logic [31:0] exp);
    special_purpose_register(1'b0, n, 32'h0);
    check(st, 3'h1);
    check(r, exp);
  endtask
  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    special_purpose_register(1'b1, n, d);
    check(st, 3'h1);
  endtask
  task automatic t_spr;
    check(machine_state, 32'h0);
    rd(`SPR_DOWN_COUNT, 32'hFFFF_FFFF);
    wr(`SPR_VERSION, 32'hFFFF_FFFF);
    rd(`SPR_VERSION, VER);
    special_purpose_register(1'b0, 10'h3E0, 32'h0);
    check(st, 3'h2);
    wr(`SPR_LINK, 32'h1234_5678);
    rd(`SPR_LINK, 32'h1234_5678);
    special_purpose_register(1'b1, `SPR_IXLT_BASE + 10'h8, 32'h0000_0FFE);
    check(st, 3'h2);
    wr(`SPR_CONFIG_TWO, 32'h0004_000D);
    check({little_endian_en, way_lock, high_bat_en}, 5'b1_101_1);
    wr(`SPR_IXLT_BASE + 10'h8, 32'h0000_0FFE);
    rd(`SPR_IXLT_BASE + 10'h8, 32'h0000_0FFE);
    $display("special register test done");
  endtask
  task automatic t_arrays;
    cyc(1);
    {int_we, int_wr_idx, int_wr_data} = {1'b1, 5'h1F, 32'hA5A5_0001};
    {float_we, float_wr_idx, float_wr_data} = {1'b1, 5'h05, 64'h0123_4567_89AB_CDEF};
    {seg_we, seg_wr_idx, seg_wr_data} = {1'b1, 4'h3, 32'h0000_7E03};
    {flags_field_we, flags_field_data} = {8'h81, 32'hFFFF_FFFF};
    cyc(1);
    {int_wr_idx, int_wr_data, float_we, seg_we, flags_field_we} = {5'h00, 32'h5A5A_0002, 10'h000};
    {float_rd_idx, seg_data_idx, seg_fetch_idx} = {5'h05, 4'h3, 4'h3};
    cyc(1);
    {int_we, int_rd_a_idx, int_rd_b_idx} = {1'b0, 5'h1F, 5'h00};
    cyc(1);
    check(int_rd_a_data, 32'hA5A5_0001);
    check(int_rd_b_data, 32'h5A5A_0002);
    check(float_rd_data, 64'h0123_4567_89AB_CDEF);
    check({seg_data_out, seg_fetch_out}, {2{32'h0000_7E03}});
    check(condition_flags, 32'hF000_000F);
    $display("array test done");
  endtask
  task automatic t_priv;
    {ms_we, ms_wr_data} = {1'b1, 32'h0000_4000};
    cyc(1);
    ms_we = 1'b0;
    special_purpose_register(1'b0, `SPR_FAULT_CAUSE, 32'h0);
    check(st, 3'h4);
    rd(`SPR_LINK, 32'h1234_5678);
    {ms_we, ms_wr_data, seg_we, seg_wr_data} = {1'b1, 32'h0, 1'b1, 32'h0000_0BAD};
    cyc(1);
    {ms_we, seg_we} = 2'h0;
    check(priv_fault, 1'b1);
    cyc(1);
    check({machine_state, seg_data_out}, {32'h0000_4000, 32'h0000_7E03});
    {exc_take, exc_pc} = {1'b1, 32'h0000_0900};
    cyc(1);
    exc_take = 1'b0;
    check(machine_state, 32'h0);
    $display("privilege test done");
  endtask
  task automatic t_exc;
    {ms_we, ms_wr_data} = {1'b1, 32'h0002_8000};
    cyc(1);
    {ms_we, exc_take, exc_pc} = {1'b0, 1'b1, 32'h0000_0700};
    cyc(1);
    exc_take = 1'b0;
    check(machine_state, 32'h0002_0000);
    rd(`SPR_SAVE_ADDR, 32'h0000_0700);
    rd(`SPR_SAVE_STATUS, 32'h0002_8000);
    exc_return = 1'b1;
    cyc(1);
    exc_return = 1'b0;
    check(restore_valid, 1'b1);
    check({restore_pc, machine_state}, {32'h0000_0700, 32'h0002_8000});
    {ms_we, ms_wr_data} = {1'b1, 32'h0000_8000};
    cyc(1);
    {ms_we, crit_int} = 2'h1;
    hits = 0;
    repeat (3)
    begin
      cyc(1);
      hits += crit_taken;
    end
    check(hits, 0);
    {crit_int, ms_we, ms_wr_data} = {2'h1, 32'h0002_8000};
    cyc(1);
    {ms_we, crit_int} = 2'h1;
    cyc(1);
    crit_int = 1'b0;
    check({crit_taken, machine_state}, {1'b1, 32'h0});
    crit_return = 1'b1;
    cyc(1);
    crit_return = 1'b0;
    check({restore_valid, machine_state}, {1'b1, 32'h0002_8000});
    check(restore_pc, 32'h0000_0700);
    $display("exception test done");
  endtask
  task automatic t_hw;
    wr(`SPR_LOOP, 32'h2);
    loop_dec = 1'b1;
    cyc(2);
    {loop_dec, link_we, link_addr, flags_update, flags_ov, flags_ca} = {2'h1, 32'h0000_2468, 3'h7};
    check({loop_zero, loop_counter}, {1'b1, 32'h0});
    cyc(1);
    {link_we, flags_ov, flags_ca} = 3'h0;
    check(branch_link_address, 32'h0000_2468);
    check(integer_exception_flags, 32'hE000_0000);
    cyc(1);
    flags_update = 1'b0;
    check(integer_exception_flags, 32'h8000_0000);
    {data_fault, fault_is_bp, fault_cause, fault_ea} = {2'h3, 32'h0000_0010, 32'h0000_3004};
    cyc(1);
    {data_fault, fault_is_bp, align_fault, fault_ea} = {3'h1, 32'h0000_3009};
    cyc(1);
    align_fault = 1'b0;
    rd(`SPR_FAULT_CAUSE, 32'h0000_0210);
    rd(`SPR_FAULT_ADDR, 32'h0000_3009);
    {data_miss, miss_ea, miss_primary} = {1'b1, 32'h0000_5000, 32'h0001_0040};
    {miss_secondary, miss_compare} = {32'h0001_FFC0, 32'h8000_1234};
    cyc(1);
    {data_miss, instr_miss, miss_ea} = {2'h1, 32'h0000_6000};
    cyc(1);
    instr_miss = 1'b0;
    wr(`SPR_DATA_MISS, 32'h0);
    rd(`SPR_DATA_MISS, 32'h0000_5000);
    rd(`SPR_INSTR_MISS, 32'h0000_6000);
    rd(`SPR_SECONDARY_GROUP, 32'h0001_FFC0);
    rd(`SPR_DATA_CMP, 32'h8000_1234);
    wr(`SPR_REAL_PAGE, 32'h0000_0ABC);
    rd(`SPR_REAL_PAGE, 32'h0000_0ABC);
    wr(`SPR_INSTR_BP, 32'h0000_4002);
    wr(`SPR_INSTR_BP_CTRL, 32'h0000_0002);
    {dispatch_valid, dispatch_addr} = {1'b1, 32'h0000_4001};
    cyc(1);
    check(instr_bp_hit, 1'b1);
    dispatch_addr = 32'h0000_4004;
    cyc(1);
    check(instr_bp_hit, 1'b0);
    wr(`SPR_DATA_BP, 32'h0000_5001);
    {data_access, data_is_write, data_addr} = {2'h2, 32'h0000_5004};
    cyc(1);
    check(data_bp_hit, 1'b1);
    data_is_write = 1'b1;
    cyc(1);
    check(data_bp_hit, 1'b0);
    $display("hardware update test done");
  endtask
  task automatic t_timer;
    wr(`SPR_DOWN_COUNT, 32'h1);
    wr(`SPR_TOD_LOWER_WR, 32'hFFFF_FFFF);
    wr(`SPR_TOD_UPPER_WR, 32'h0);
    {bus_tick, tb_enable} = 2'h3;
    hits = 0;
    for (int i = 0; i < 12; i++)
    begin
      cyc(1);
      hits += dec_exception;
      if (i == 7)
        {bus_tick, tb_enable} = 2'h0;
    end
    check(hits, 1);
    rd(`SPR_TOD_LOWER_RD, 32'h1);
    rd(`SPR_TOD_UPPER_RD, 32'h1);
    bus_tick = 1'b1;
    cyc(4);
    bus_tick = 1'b0;
    rd(`SPR_TOD_LOWER_RD, 32'h1);
    rd(`SPR_DOWN_COUNT, 32'hFFFF_FFFE);
    $display("timer test done");
  endtask
  initial
  begin
    rst = 1'b1;
    {int_we, float_we, seg_we, ms_we, spr_req, spr_write, loop_dec, link_we, flags_update, flags_ov} = '0;
    {flags_ca, exc_take, exc_return, crit_int, crit_return, data_fault, align_fault, fault_is_bp} = '0;
    {bus_tick, tb_enable, instr_miss, data_miss, dispatch_valid, data_access, data_is_write} = '0;
    {seg_wr_idx, seg_data_idx, seg_fetch_idx, int_rd_a_idx, int_rd_b_idx, int_wr_idx, float_rd_idx} = '0;
    {float_wr_idx, flags_field_we, spr_num, int_wr_data, flags_field_data, seg_wr_data, ms_wr_data} = '0;
    {spr_wdata, link_addr, exc_pc, fault_cause, fault_ea, miss_ea, miss_primary, miss_secondary} = '0;
    {miss_compare, dispatch_addr, data_addr, float_wr_data} = '0;
    cyc(12);
    rst = 1'b0;
    t_spr();
    t_arrays();
    t_priv();
    t_exc();
    t_hw();
    t_timer();
    summarize();
  end
  initial
  begin
    #500000;
    error_cnt++;
    $display("[ERR] %0t run timed out", $time);
    summarize();
  end
endmodule // tb_top
bind core_register_set core_register_set_checker chk (.*);
`default_nettype wire
